/* ee_defines.svh */
// Purpose : Constants for the serial EEPROM pin interface block
// Assumes : 200 MHz system clock
// Notes   : Offsets, fields, opcodes and timing counts live here as macros
`ifndef EE_DEFINES_SVH
`define EE_DEFINES_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define EE_CLK_PERIOD_NS   5
`define EE_WRITE_TIME_NS   5000000
`define EE_BUSY_CNT_W      20

// ----------------------------------------------------------------------
// Opcodes, sent MSB first
// ----------------------------------------------------------------------
`define EE_OP_WRITE_ENABLE  8'h06
`define EE_OP_WRITE_DISABLE 8'h04
`define EE_OP_STATUS_READ   8'h05
`define EE_OP_STATUS_WRITE  8'h01
`define EE_OP_MEM_READ      8'h03
`define EE_OP_MEM_WRITE     8'h02

// ----------------------------------------------------------------------
// Array and status byte layout
// ----------------------------------------------------------------------
`define EE_ADDR_W          11
`define EE_DATA_W          8
`define EE_PAGE_W          5
`define EE_STAT_BUSY_BIT   0
`define EE_STAT_WEL_BIT    1
`define EE_STAT_WMASK      8'h8C
`define EE_STAT_RESET      8'h00

`endif

/* ee_pkg.sv */
// Purpose : Types shared by the serial EEPROM pin interface
// Assumes : Nothing beyond the defines header
// Notes   : Only types live here
package ee_pkg;

  // --------------------------------------------------------------------
  // Transaction phases
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_ADDR_HI,
    ST_ADDR_LO,
    ST_READ,
    ST_WRITE,
    ST_STAT_RD,
    ST_STAT_WR,
    ST_CMD_END
  } ee_phase_type;

endpackage : ee_pkg

/* ee_mem.sv */
// Purpose : Byte array of the EEPROM with registered read data
// Assumes : One write port and one read port on the same clock
// Notes   : Contents are not reset; read data comes from a register
`timescale 1ns/1ps
module ee_mem #(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 8
)(
  input  wire logic              sys_clk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              wr_en_i,
  input  wire logic [ADDR_W-1:0] wr_addr_i,
  input  wire logic [DATA_W-1:0] wr_data_i,
  input  wire logic [ADDR_W-1:0] rd_addr_i,
  output logic      [DATA_W-1:0] rd_data_o
);

  logic [DATA_W-1:0] mem_ff [0:(1<<ADDR_W)-1];

  // Write port, no reset so it maps onto RAM
  always_ff @(posedge sys_clk_i) begin
    if (wr_en_i) begin
      mem_ff[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read, one cycle latency
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rd_data_o <= '0;
    end else begin
      rd_data_o <= mem_ff[rd_addr_i];
    end
  end

endmodule : ee_mem

/* ee_spi_slave.sv */
// Purpose : Pin-level SPI slave of a small serial EEPROM
// Assumes : Pins are asynchronous; serial clock half period of 3+ system clocks
// Notes   : Pins are oversampled by sys_clk_i; no second clock domain
`timescale 1ns/1ps
`include "ee_defines.svh"
module ee_spi_slave #(
  parameter int WRITE_CYCLES = `EE_WRITE_TIME_NS / `EE_CLK_PERIOD_NS
)(
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic si_i,
  input  wire logic hold_n_i,
  output logic      so_o,
  output logic      so_oe_o,
  output logic      write_busy_o,
  output logic      standby_o
);
  import ee_pkg::*;

  localparam int AW = `EE_ADDR_W;
  localparam int DW = `EE_DATA_W;
  localparam int PW = `EE_PAGE_W;
  localparam logic [`EE_BUSY_CNT_W-1:0] BUSY_LOAD = `EE_BUSY_CNT_W'(WRITE_CYCLES - 1);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic op_valid(input logic [7:0] op);
    op_valid = (op == `EE_OP_WRITE_ENABLE) || (op == `EE_OP_WRITE_DISABLE) ||
               (op == `EE_OP_STATUS_READ)  || (op == `EE_OP_STATUS_WRITE)  ||
               (op == `EE_OP_MEM_READ)     || (op == `EE_OP_MEM_WRITE);
  endfunction : op_valid

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic cs_s1, cs_s2, cs_s3;
  logic sck_s1, sck_s2, sck_s3;
  logic si_s1, si_s2;
  logic hold_s1, hold_s2, hold_s3;

  // Two flops per pin; the third stage only feeds edge detection
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      {cs_s3, cs_s2, cs_s1}       <= 3'h7;
      {sck_s3, sck_s2, sck_s1}    <= 3'h0;
      {si_s2, si_s1}              <= 2'h0;
      {hold_s3, hold_s2, hold_s1} <= 3'h7;
    end else begin
      {cs_s3, cs_s2, cs_s1}       <= {cs_s2, cs_s1, cs_n_i};
      {sck_s3, sck_s2, sck_s1}    <= {sck_s2, sck_s1, sck_i};
      {si_s2, si_s1}              <= {si_s1, si_i};
      {hold_s3, hold_s2, hold_s1} <= {hold_s2, hold_s1, hold_n_i};
    end
  end

  // ----------------------------------------------------------------------
  // State and decode
  // ----------------------------------------------------------------------
  ee_phase_type        state_ff;
  logic                ignore_ff;
  logic [2:0]          bit_cnt_ff;
  logic [7:0]          rx_ff, tx_ff, op_ff, stat_pend_ff;
  logic [2:0]          addr_hi_ff;
  logic [AW-1:0]       addr_ff;
  logic                held_ff, drive_ff, so_ff, so_oe_ff;
  logic                wel_ff, busy_ff, wrote_ff, stat_wr_ff, standby_ff;
  logic [7:0]          nv_stat_ff;
  logic [`EE_BUSY_CNT_W-1:0] busy_cnt_ff;
  logic [DW-1:0]       mem_rd;

  wire       sel          = ~cs_s2;
  wire       cs_rise      = cs_s2 & ~cs_s3;
  wire       hold_fall    = sel & hold_s3 & ~hold_s2;
  wire       hold_rise    = sel & ~hold_s3 & hold_s2;
  wire       act          = sel & ~held_ff & ~ignore_ff;
  wire       sck_rise_act = act & sck_s2 & ~sck_s3;
  wire       sck_fall_act = act & ~sck_s2 & sck_s3;
  wire       byte_done    = sck_rise_act & (bit_cnt_ff == 3'h7);
  wire [7:0] rx_byte      = {rx_ff[6:0], si_s2};
  wire [7:0] stat_byte    = (nv_stat_ff & `EE_STAT_WMASK) |
                            {6'h00, wel_ff, busy_ff};
  wire       mem_we       = byte_done & (state_ff == ST_WRITE);
  wire       write_start  = cs_rise & ((state_ff == ST_WRITE) & wrote_ff & (bit_cnt_ff == 3'h0) |
                                       (state_ff == ST_CMD_END) & stat_wr_ff);
  wire       busy_done    = busy_ff & (busy_cnt_ff == '0);
  wire [AW-1:0] page_next = {addr_ff[AW-1:PW], addr_ff[PW-1:0] + PW'(1)};

  // Pause latch, edge triggered and cleared by deselect
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      held_ff <= 1'b0;
    end else if (!sel) begin
      held_ff <= 1'b0;
    end else if (hold_fall) begin
      held_ff <= 1'b1;
    end else if (hold_rise) begin
      held_ff <= 1'b0;
    end
  end

  // Receive shifter and bit counter; frozen while paused so shifting resumes in place
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_ff      <= 8'h00;
      bit_cnt_ff <= 3'h0;
    end else if (!sel) begin
      bit_cnt_ff <= 3'h0;
    end else if (sck_rise_act) begin
      rx_ff      <= rx_byte;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  // Transaction phases; deselect returns to opcode phase
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_ff   <= ST_OPCODE;
      ignore_ff  <= 1'b0;
      op_ff      <= 8'h00;
      addr_hi_ff <= 3'h0;
      addr_ff    <= '0;
      wrote_ff   <= 1'b0;
      stat_wr_ff <= 1'b0;
    end else if (!sel) begin
      state_ff  <= ST_OPCODE;
      ignore_ff <= 1'b0;
      wrote_ff  <= 1'b0;
      if (!busy_ff && !write_start) begin
        stat_wr_ff <= 1'b0;
      end
    end else if (state_ff == ST_CMD_END && sck_rise_act) begin
      ignore_ff <= 1'b1;                                               // Extra clock cancels the command
    end else if (byte_done) begin
      unique case (state_ff)
        ST_OPCODE: begin
          op_ff <= rx_byte;
          if (!op_valid(rx_byte) || (busy_ff && rx_byte != `EE_OP_STATUS_READ)) begin
            ignore_ff <= 1'b1;
          end else if (rx_byte == `EE_OP_STATUS_READ) begin
            state_ff <= ST_STAT_RD;
          end else if (rx_byte == `EE_OP_MEM_READ) begin
            state_ff <= ST_ADDR_HI;
          end else if (rx_byte == `EE_OP_WRITE_ENABLE || rx_byte == `EE_OP_WRITE_DISABLE) begin
            state_ff <= ST_CMD_END;
          end else if (!wel_ff) begin
            ignore_ff <= 1'b1;                                         // Writes need the enable latch
          end else begin
            state_ff <= (rx_byte == `EE_OP_STATUS_WRITE) ? ST_STAT_WR : ST_ADDR_HI;
          end
        end
        ST_ADDR_HI: begin
          addr_hi_ff <= rx_byte[2:0];
          state_ff   <= ST_ADDR_LO;
        end
        ST_ADDR_LO: begin
          addr_ff  <= {addr_hi_ff, rx_byte};
          state_ff <= (op_ff == `EE_OP_MEM_WRITE) ? ST_WRITE : ST_READ;
        end
        ST_READ:    addr_ff <= addr_ff + AW'(1);                       // Sequential read
        ST_WRITE: begin
          addr_ff  <= page_next;                                       // Wraps inside the page
          wrote_ff <= 1'b1;
        end
        ST_STAT_WR: begin
          stat_wr_ff <= 1'b1;
          state_ff   <= ST_CMD_END;
        end
        ST_STAT_RD, ST_CMD_END: state_ff <= state_ff;
      endcase
    end
  end

  // Enable latch, status bits and internal write timer
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wel_ff       <= 1'b0;
      busy_ff      <= 1'b0;
      busy_cnt_ff  <= '0;
      nv_stat_ff   <= `EE_STAT_RESET;
      stat_pend_ff <= 8'h00;
    end else begin
      if (byte_done && state_ff == ST_STAT_WR) begin
        stat_pend_ff <= rx_byte;
      end
      if (cs_rise && state_ff == ST_CMD_END && !ignore_ff) begin
        if (op_ff == `EE_OP_WRITE_ENABLE) wel_ff <= 1'b1;
        if (op_ff == `EE_OP_WRITE_DISABLE) wel_ff <= 1'b0;
      end
      if (write_start && !ignore_ff) begin
        busy_ff     <= 1'b1;
        busy_cnt_ff <= BUSY_LOAD;
      end else if (busy_done) begin
        busy_ff <= 1'b0;
        wel_ff  <= 1'b0;
        if (stat_wr_ff) nv_stat_ff <= stat_pend_ff & `EE_STAT_WMASK;
      end else if (busy_ff) begin
        busy_cnt_ff <= busy_cnt_ff - `EE_BUSY_CNT_W'(1);
      end
    end
  end

  // Output shifter: new bit on each falling edge, byte loaded at byte boundary
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      so_ff    <= 1'b0;
      tx_ff    <= 8'h00;
      drive_ff <= 1'b0;
    end else if (!sel) begin
      drive_ff <= 1'b0;
    end else if (sck_fall_act) begin
      if (bit_cnt_ff == 3'h0 && (state_ff == ST_READ || state_ff == ST_STAT_RD)) begin
        so_ff    <= (state_ff == ST_READ) ? mem_rd[7] : stat_byte[7];
        tx_ff    <= (state_ff == ST_READ) ? {mem_rd[6:0], 1'b0} : {stat_byte[6:0], 1'b0};
        drive_ff <= 1'b1;
      end else if (drive_ff) begin
        so_ff <= tx_ff[7];
        tx_ff <= {tx_ff[6:0], 1'b0};
      end
    end
  end

  // Registered pin outputs; enable drops while deselected or paused
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      so_oe_ff   <= 1'b0;
      standby_ff <= 1'b1;
    end else begin
      so_oe_ff   <= drive_ff & sel & ~held_ff & ~hold_fall;
      // Follows the next busy value so standby never overlaps a starting or running write
      standby_ff <= cs_s2 & ~(busy_ff & ~busy_done) & ~(write_start & ~ignore_ff);
    end
  end

  assign so_o         = so_ff;
  assign so_oe_o      = so_oe_ff;
  assign write_busy_o = busy_ff;
  assign standby_o    = standby_ff;

  // ----------------------------------------------------------------------
  // Array
  // ----------------------------------------------------------------------
  ee_mem #(.ADDR_W(AW), .DATA_W(DW)) u_mem (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .wr_en_i   (mem_we),
    .wr_addr_i (addr_ff),
    .wr_data_i (rx_byte),
    .rd_addr_i (addr_ff),
    .rd_data_o (mem_rd)
  );

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_pause_enter;
    hold_fall;
  endsequence
  sequence s_write_start;
    write_start && !ignore_ff;
  endsequence

  deselect_float_a: assert property (cs_s2 && $past(cs_s2) |-> !so_oe_o)
    else $error("output driven while deselected");
  select_gate_a: assert property (!sel |=> bit_cnt_ff == 3'h0 && state_ff == ST_OPCODE)
    else $error("activity accepted while deselected");
  standby_idle_a: assert property (standby_o |-> !write_busy_o && $past(cs_s2))
    else $error("standby shown during write or select");
  rise_sample_a: assert property (sck_rise_act |=> rx_ff[0] == $past(si_s2) &&
                                  bit_cnt_ff == $past(bit_cnt_ff) + 3'h1)
    else $error("serial input not sampled on rising edge");
  fall_update_a: assert property (sel && $changed(so_o) |-> $past(sck_fall_act))
    else $error("output changed away from falling edge");
  pause_freeze_a: assert property (held_ff && sel |=> $stable(bit_cnt_ff) && $stable(rx_ff) &&
                                   $stable(state_ff))
    else $error("transaction moved while paused");
  pause_float_a: assert property (s_pause_enter |=> ##1 !so_oe_o [*2])
    else $error("output driven while paused");
  pause_edges_a: assert property (s_pause_enter |=> held_ff)
    else $error("pause not entered on falling edge");
  pause_leave_a: assert property (hold_rise && !hold_fall |=> !held_ff)
    else $error("pause not left on rising edge");
  bad_opcode_a: assert property (byte_done && state_ff == ST_OPCODE && !op_valid(rx_byte)
                                 |=> ignore_ff && !sck_rise_act)
    else $error("undefined opcode not ignored");
  addr_drop_a: assert property (byte_done && state_ff == ST_ADDR_LO |=>
                                addr_ff == {$past(addr_hi_ff), $past(rx_byte)})
    else $error("address not formed from low eleven bits");
  busy_flag_a: assert property (s_write_start |=> busy_ff [*8] ##0 stat_byte[0])
    else $error("busy status bit not held during write");

endmodule : ee_spi_slave

/* ee_host.sv */
// Purpose : Behavioural SPI host that drives the serial EEPROM pins
// Assumes : Mode 0, serial clock period 48 ns, idle low between frames
// Notes   : Pins move on their own timing, unrelated to the system clock
`timescale 1ns/1ps
module ee_host (
  output logic      cs_n_o,
  output logic      sck_o,
  output logic      si_o,
  output logic      hold_n_o,
  input  wire logic so_i,
  input  wire logic so_oe_i
);
  logic so_last = 1'b0;
  // A released line shows the inverse of its last level, so floating reads never pass
  wire  so_line = so_oe_i ? so_i : ~so_last;

  initial begin
    cs_n_o   = 1'b1;
    sck_o    = 1'b0;
    si_o     = 1'b0;
    hold_n_o = 1'b1;
  end

  // Remember the last driven level of the output line
  always @* begin
    if (so_oe_i) so_last = so_i;
  end

  // ----------------------------------------------------------------------
  // Framing
  // ----------------------------------------------------------------------
  // Select; the gap covers the synchroniser delay before the first clock
  task automatic frame_open();
    #20 cs_n_o = 1'b0;
    #40;
  endtask : frame_open

  // Release; the gap keeps chip select high long enough between frames
  task automatic frame_close();
    #20 cs_n_o = 1'b1;
    #40;
  endtask : frame_close

  // Shift n bits, MSB first, sampling the line at each rising edge; clocks past eight carry zeros
  task automatic xfer(input int n, input logic [7:0] tx, output logic [7:0] rx, output logic oe);
    rx = 8'h00;
    oe = 1'b0;
    for (int i = 0; i < n; i++) begin
      si_o = (i < 8) ? tx[7 - i] : 1'b0;
      #12 sck_o = 1'b1;
      rx = {rx[6:0], so_line};
      oe = oe | so_oe_i;
      #24 sck_o = 1'b0;
      #12;
    end
    si_o = ~si_o;
  endtask : xfer

  // Pause with chip select kept low, clocking junk meanwhile
  task automatic pause(input int n, output logic oe);
    #6 hold_n_o = 1'b0;
    #30;
    oe = so_oe_i;
    repeat (n) begin
      si_o = ~si_o;
      #24 sck_o = 1'b1;
      oe = oe | so_oe_i;
      #24 sck_o = 1'b0;
    end
    #12 hold_n_o = 1'b1;
    #30;
  endtask : pause
endmodule : ee_host

/* tb_top.sv */
// Purpose : Self-checking bench for the EEPROM serial pin interface
// Assumes : Short write timer through WRITE_CYCLES
// Notes   : Expected bytes follow the opcode and status layout
`timescale 1ns/1ps
module tb_top;
  localparam int WCYC = 400;
  logic       sys_clk_i;
  logic       sys_rst_i;
  wire        cs_n;
  wire        sck;
  wire        si;
  wire        hold_n;
  wire        so;
  wire        so_oe;
  wire        busy;
  wire        standby;
  int         n_errors;
  int         comparisons;
  logic [7:0] rx;
  logic [7:0] r1;
  logic       oe;

  ee_spi_slave #(.WRITE_CYCLES(WCYC)) u_ee_spi_slave (
    .sys_clk_i    (sys_clk_i),
    .sys_rst_i    (sys_rst_i),
    .cs_n_i       (cs_n),
    .sck_i        (sck),
    .si_i         (si),
    .hold_n_i     (hold_n),
    .so_o         (so),
    .so_oe_o      (so_oe),
    .write_busy_o (busy),
    .standby_o    (standby)
  );

  ee_host u_ee_host (
    .cs_n_o   (cs_n),
    .sck_o    (sck),
    .si_o     (si),
    .hold_n_o (hold_n),
    .so_i     (so),
    .so_oe_i  (so_oe)
  );

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim

  // One opcode alone in a frame, n clocks long
  task automatic op1(input logic [7:0] op, input int n);
    u_ee_host.frame_open;
    u_ee_host.xfer(n, op, rx, oe);
    u_ee_host.frame_close;
  endtask : op1

  task automatic op_status_read(input logic [7:0] exp);
    u_ee_host.frame_open;
    u_ee_host.xfer(8, 8'h05, rx, oe);
    u_ee_host.xfer(8, 8'h00, rx, oe);
    u_ee_host.frame_close;
    check("status", rx, exp);
  endtask : op_status_read

  // Bounded wait for the write timer to run out
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < WCYC + 20) begin
      @(negedge sys_clk_i);
      k++;
    end
    check("busy_end", {7'h00, busy}, 8'h00);
    check("standby", {7'h00, standby}, 8'h01);
  endtask : wait_idle

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic t_write();
    op1(8'h06, 8);
    op_status_read(8'h02);
    u_ee_host.frame_open;
    u_ee_host.xfer(8, 8'h02, rx, oe);
    u_ee_host.xfer(8, 8'hF9, rx, oe); // Top address bits set on purpose
    u_ee_host.xfer(8, 8'h23, rx, oe);
    u_ee_host.xfer(8, 8'hA5, rx, oe);
    u_ee_host.xfer(8, 8'h5A, rx, oe);
    u_ee_host.frame_close;
    check("busy", {7'h00, busy}, 8'h01);
    check("standby_busy", {7'h00, standby}, 8'h00);
    op_status_read(8'h03);
    wait_idle();
    op_status_read(8'h00);
    $display("t_write done");
  endtask : t_write

  task automatic t_read_pause();
    u_ee_host.frame_open;
    u_ee_host.xfer(8, 8'h03, rx, oe);
    u_ee_host.xfer(8, 8'h01, rx, oe);
    u_ee_host.xfer(8, 8'h23, rx, oe);
    u_ee_host.xfer(4, 8'h00, r1, oe);
    u_ee_host.pause(3, oe);
    check("oe_paused", {7'h00, oe}, 8'h00);
    check("standby_paused", {7'h00, standby}, 8'h00);
    u_ee_host.xfer(4, 8'h00, rx, oe);
    check("read0", {r1[3:0], rx[3:0]}, 8'hA5);
    u_ee_host.xfer(8, 8'h00, rx, oe);
    check("read1", rx, 8'h5A);
    u_ee_host.frame_close;
    check("oe_desel", {7'h00, so_oe}, 8'h00);
    check("standby_desel", {7'h00, standby}, 8'h01);
    $display("t_read_pause done");
  endtask : t_read_pause

  task automatic t_bad_op();
    logic any;
    any = 1'b0;
    // Clocks with chip select high must leave no trace
    u_ee_host.xfer(8, 8'h06, rx, oe);
    check("oe_unselected", {7'h00, oe}, 8'h00);
    op_status_read(8'h00);
    u_ee_host.frame_open;
    for (int i = 0; i < 8; i++) begin
      u_ee_host.xfer(8, (i == 0) ? 8'hFF : 8'h03, rx, oe);
      any = any | oe;
    end
    u_ee_host.frame_close;
    check("oe_bad_op", {7'h00, any}, 8'h00);
    $display("t_bad_op done");
  endtask : t_bad_op

  // Write refused after a cancelled enable and after disable
  task automatic t_guard();
    for (int c = 0; c < 2; c++) begin
      op1(8'h06, (c == 0) ? 9 : 8);
      if (c == 1) op1(8'h04, 8);
      op_status_read(8'h00);
      u_ee_host.frame_open;
      u_ee_host.xfer(8, 8'h02, rx, oe);
      u_ee_host.xfer(8, 8'h01, rx, oe);
      u_ee_host.xfer(8, 8'h23, rx, oe);
      u_ee_host.xfer(8, 8'h77, rx, oe);
      u_ee_host.frame_close;
      check("busy_refused", {7'h00, busy}, 8'h00);
    end
    $display("t_guard done");
  endtask : t_guard

  task automatic t_status_write();
    op1(8'h06, 8);
    u_ee_host.frame_open;
    u_ee_host.xfer(8, 8'h01, rx, oe);
    u_ee_host.xfer(8, 8'hFF, rx, oe);
    u_ee_host.frame_close;
    check("busy_status", {7'h00, busy}, 8'h01);
    wait_idle();
    op_status_read(8'h8C);
    $display("t_status_write done");
  endtask : t_status_write

  // ----------------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    n_errors    = 0;
    comparisons = 0;
    sys_rst_i   = 1'b1;
    repeat (10) @(posedge sys_clk_i);
    @(negedge sys_clk_i) sys_rst_i = 1'b0;
    check("oe_reset", {7'h00, so_oe}, 8'h00);
    check("standby_reset", {6'h00, busy, standby}, 8'h01);
    $display("t_reset done");
    t_write();
    t_read_pause();
    t_bad_op();
    t_guard();
    t_status_write();
    end_sim();
  end

  // Whole run needs well under 100 us
  initial begin
    #200000;
    n_errors++;
    $display("Watchdog expired");
    end_sim();
  end
endmodule : tb_top
